// file: rtl/amw_async_ctrl.sv
`timescale 1ns/1ps
module amw_async_ctrl
   import amw_pkg::*;
#(
   parameter bit HAS_WAIT = 1'b1
) (
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RSTN,
   // Register port
   input  wire logic [3:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [31:0] REG_RDATA,
   // Requester side
   input  wire amw_req_t    REQ,
   input  wire logic        REQ_VALID,
   output logic             REQ_READY,
   output logic      [31:0] RSP_DATA,
   output logic             RSP_VALID,
   // SDRAM side hand-off
   input  wire logic        SDRAM_REQ,
   output logic             SDRAM_GRANT,
   // Memory pins
   output amw_pins_t        PINS,
   input  wire logic [31:0] DATA_IN,
   input  wire logic        WAIT_IN,
   // Interrupt
   output logic             IRQ
);

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [31:0] timing_reg;
   logic [31:0] waitcfg_reg;
   logic        mask_at_reg, mask_wr_reg;
   logic        nand_mode_reg;
   logic        stat_at_reg, stat_wr_reg;

   wire logic       ss       = timing_reg[POS_SS];
   wire logic       ew       = HAS_WAIT & timing_reg[POS_EW];
   wire logic [1:0] bw_sel   = timing_reg[POS_BUS_WIDTH_SEL +: 2];
   wire logic [1:0] turn_gap = timing_reg[POS_TA +: 2];
   wire logic       wpol     = waitcfg_reg[POS_WP];
   wire logic [7:0] max_wait = waitcfg_reg[POS_MAX_WAIT_COUNT +: 8];

   // Pulses from the access engine
   logic timeout_evt;
   logic wait_rise_evt;

   // Configuration registers; reserved fields stay zero without wait
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         timing_reg    <= HAS_WAIT ? RST_TIMING
                                   : (RST_TIMING & ~(32'h1 << POS_EW));
         waitcfg_reg   <= HAS_WAIT ? RST_WAITCFG : 32'h0000_0000;
         nand_mode_reg <= 1'b0;
      end else if (REG_WR) begin
         unique case (REG_ADDR)
            ADDR_TIMING: begin
               timing_reg <= HAS_WAIT ? REG_WDATA
                                      : (REG_WDATA & ~(32'h1 << POS_EW));
            end
            ADDR_WAITCFG: begin
               if (HAS_WAIT) waitcfg_reg <= REG_WDATA & 32'h1000_00FF;
            end
            ADDR_CTRL: nand_mode_reg <= REG_WDATA[POS_NAND];
            default: ;
         endcase
      end
   end

   // Shared mask; set and clear registers both steer it
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         mask_at_reg <= 1'b0;
         mask_wr_reg <= 1'b0;
      end else if (REG_WR && HAS_WAIT) begin
         if (REG_ADDR == ADDR_MASK_SET) begin
            if (REG_WDATA[POS_IRQ_AT]) mask_at_reg <= 1'b1;
            if (REG_WDATA[POS_IRQ_WR]) mask_wr_reg <= 1'b1;
         end else if (REG_ADDR == ADDR_MASK_CLR) begin
            if (REG_WDATA[POS_IRQ_AT]) mask_at_reg <= 1'b0;
            if (REG_WDATA[POS_IRQ_WR]) mask_wr_reg <= 1'b0;
         end
      end
   end

   // Sticky event status; a new event wins over a write-one clear
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         stat_at_reg <= 1'b0;
         stat_wr_reg <= 1'b0;
      end else begin
         if (timeout_evt)
            stat_at_reg <= 1'b1;
         else if (REG_WR && REG_ADDR == ADDR_STATUS && REG_WDATA[POS_IRQ_AT])
            stat_at_reg <= 1'b0;
         if (wait_rise_evt)
            stat_wr_reg <= 1'b1;
         else if (REG_WR && REG_ADDR == ADDR_STATUS && REG_WDATA[POS_IRQ_WR])
            stat_wr_reg <= 1'b0;
      end
   end

   // Interrupt line gated by the mask
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) IRQ <= 1'b0;
      else IRQ <= (stat_at_reg & mask_at_reg)
                | (stat_wr_reg & mask_wr_reg);
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) REG_RDATA <= 32'h0000_0000;
      else if (REG_RD) begin
         unique case (REG_ADDR)
            ADDR_TIMING:  REG_RDATA <= timing_reg;
            ADDR_WAITCFG: REG_RDATA <= waitcfg_reg;
            ADDR_MASK_SET, ADDR_MASK_CLR:
               REG_RDATA <= {30'h0, mask_wr_reg, mask_at_reg};
            ADDR_STATUS:  REG_RDATA <= {30'h0, stat_wr_reg, stat_at_reg};
            ADDR_CTRL:    REG_RDATA <= {31'h0, nand_mode_reg};
            default:      REG_RDATA <= 32'h0000_0000;
         endcase
      end else REG_RDATA <= 32'h0000_0000;
   end

   // -----------------------------------------------------------------
   // Access engine
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_TURN, ST_SETUP, ST_STROBE, ST_HOLD, ST_SDRAM
   } amw_state_t;

   amw_state_t  state_reg;
   amw_req_t    req_reg;
   logic [11:0] cnt_reg;
   logic [11:0] wait_cnt_reg;
   logic [1:0]  beat_reg;
   logic        last_write_reg, any_async_reg;
   logic [31:0] rd_acc_reg;
   logic        wait_prev_reg;

   // Index of the last beat per transfer for the bus width
   function automatic logic [1:0] last_beat(input logic [1:0] w);
      unique case (w)
         WIDTH_8:  last_beat = 2'd3;
         WIDTH_16: last_beat = 2'd1;
         default:  last_beat = 2'd0;
      endcase
   endfunction : last_beat

   // Field pick by direction
   function automatic logic [5:0] pick(input logic wr, input int pw,
                                       input int pr, input int n);
      logic [5:0] v;
      v = 6'h0;
      for (int i = 0; i < n; i++) v[i] = wr ? timing_reg[pw+i]
                                            : timing_reg[pr+i];
      pick = v;
   endfunction : pick

   wire logic [5:0] setup_w  = pick(req_reg.write, POS_WSETUP, POS_RSETUP, 4);
   wire logic [5:0] strobe_w = pick(req_reg.write, POS_WSTROBE, POS_RSTROBE, 6);
   wire logic [5:0] hold_w   = pick(req_reg.write, POS_WHOLD, POS_RHOLD, 3);

   // Wait active level: fixed active high in NAND mode
   wire logic wait_act = nand_mode_reg ? WAIT_IN
                                       : (wpol ? WAIT_IN : ~WAIT_IN);
   wire logic stall    = ew & wait_act;
   // One bit wider than the counter: a full count of 255 gives 4096
   wire logic [12:0] wait_lim = 13'((max_wait + 13'd1) * WAIT_GRANULE);
   wire logic [1:0]  lane_w = bw_sel;
   wire logic [1:0]  sh = (lane_w == WIDTH_8) ? 2'd0 : 2'd1;

   // Wait rising edge detector for NAND mode
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) wait_prev_reg <= 1'b0;
      else wait_prev_reg <= WAIT_IN;
   end
   assign wait_rise_evt = HAS_WAIT & nand_mode_reg & WAIT_IN & ~wait_prev_reg;

   // Data lane for the current beat
   function automatic logic [31:0] beat_data(input logic [31:0] d,
                                             input logic [1:0] w,
                                             input logic [1:0] b);
      unique case (w)
         WIDTH_8:  beat_data = {24'h0, d[8*b +: 8]};
         WIDTH_16: beat_data = {16'h0, d[16*b[0] +: 16]};
         default:  beat_data = d;
      endcase
   endfunction : beat_data

   // Sequencer
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         state_reg      <= ST_IDLE;
         req_reg        <= '0;
         cnt_reg        <= 12'h000;
         wait_cnt_reg   <= 12'h000;
         beat_reg       <= 2'd0;
         last_write_reg <= 1'b0;
         any_async_reg  <= 1'b0;
         rd_acc_reg     <= 32'h0000_0000;
         timeout_evt    <= 1'b0;
         RSP_VALID      <= 1'b0;
         RSP_DATA       <= 32'h0000_0000;
         REQ_READY      <= 1'b0;
         SDRAM_GRANT    <= 1'b0;
      end else begin
         timeout_evt <= 1'b0;
         RSP_VALID   <= 1'b0;
         REQ_READY   <= 1'b0;
         unique case (state_reg)
            ST_IDLE: begin
               SDRAM_GRANT <= 1'b0;
               if (SDRAM_REQ) begin
                  // Idle gap before handing the bus to SDRAM
                  cnt_reg   <= {10'h0, turn_gap};
                  state_reg <= ST_SDRAM;
               end else if (REQ_VALID) begin
                  req_reg   <= REQ;
                  REQ_READY <= 1'b1;
                  beat_reg  <= 2'd0;
                  rd_acc_reg <= 32'h0000_0000;
                  cnt_reg   <= {10'h0, turn_gap};
                  if (any_async_reg && last_write_reg != REQ.write)
                     state_reg <= ST_TURN;
                  else begin
                     cnt_reg   <= 12'h000;
                     state_reg <= ST_SETUP;
                  end
               end
            end
            ST_SDRAM: begin
               if (cnt_reg == 12'h000) begin
                  SDRAM_GRANT <= 1'b1;
                  if (!SDRAM_REQ) begin
                     any_async_reg <= 1'b0;
                     state_reg     <= ST_IDLE;
                  end
               end else cnt_reg <= cnt_reg - 12'h001;
            end
            ST_TURN: begin
               if (cnt_reg == 12'h000) state_reg <= ST_SETUP;
               else cnt_reg <= cnt_reg - 12'h001;
            end
            ST_SETUP: begin
               if (cnt_reg == {6'h0, setup_w}) begin
                  cnt_reg      <= 12'h000;
                  wait_cnt_reg <= 12'h000;
                  state_reg    <= ST_STROBE;
               end else cnt_reg <= cnt_reg + 12'h001;
            end
            ST_STROBE: begin
               if (cnt_reg < {6'h0, strobe_w}) begin
                  cnt_reg <= cnt_reg + 12'h001;
               end else if (stall
                            && {1'b0, wait_cnt_reg} < wait_lim - 13'h0001)
               begin
                  wait_cnt_reg <= wait_cnt_reg + 12'h001;
               end else begin
                  if (stall) timeout_evt <= 1'b1;
                  if (!req_reg.write)
                     rd_acc_reg <= rd_acc_reg | (lane_w == WIDTH_32 ? DATA_IN
                        : lane_w == WIDTH_16
                        ? {16'h0, DATA_IN[15:0]} << (16 * beat_reg[0])
                        : {24'h0, DATA_IN[7:0]} << (8 * beat_reg));
                  cnt_reg   <= 12'h000;
                  state_reg <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (cnt_reg == {6'h0, hold_w}) begin
                  cnt_reg        <= 12'h000;
                  last_write_reg <= req_reg.write;
                  any_async_reg  <= 1'b1;
                  if (beat_reg == last_beat(bw_sel)) begin
                     RSP_VALID <= 1'b1;
                     RSP_DATA  <= rd_acc_reg;
                     state_reg <= ST_IDLE;
                  end else begin
                     beat_reg  <= beat_reg + 2'd1;
                     state_reg <= ST_SETUP;
                  end
               end else cnt_reg <= cnt_reg + 12'h001;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Registered pin drive
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         PINS <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, lane_n: 4'hF,
                   addr: 22'h0, bank: 2'h0, dout: 32'h0, doe: 1'b0};
      end else begin
         logic act, strb;
         act  = (state_reg == ST_SETUP) || (state_reg == ST_STROBE)
              || (state_reg == ST_HOLD);
         strb = (state_reg == ST_STROBE);
         PINS.cs_n   <= ~act | (ss & ~strb);
         PINS.oe_n   <= ~(strb & ~req_reg.write);
         PINS.we_n   <= ~(strb & req_reg.write & ~ss);
         PINS.lane_n <= (act & (ss | req_reg.write) & ~(~ss & ~strb))
                        ? ~req_reg.be : 4'hF;
         PINS.addr   <= act ? 22'((req_reg.addr << sh) | beat_reg) : 22'h0;
         PINS.bank   <= act ? req_reg.addr[1:0] : 2'h0;
         PINS.dout   <= beat_data(req_reg.wdata, bw_sel, beat_reg);
         PINS.doe    <= act & req_reg.write;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_irq_mask;
      @(posedge SYS_CLK) disable iff (!RSTN)
      IRQ |-> $past(mask_at_reg | mask_wr_reg);
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("interrupt without mask");

   property p_set_mask;
      @(posedge SYS_CLK) disable iff (!RSTN)
      (REG_WR && REG_ADDR == ADDR_MASK_SET && REG_WDATA[POS_IRQ_AT]
       && HAS_WAIT) |=> mask_at_reg;
   endproperty
   a_set_mask: assert property (p_set_mask)
      else $error("timeout mask not set");

   property p_clr_mask;
      @(posedge SYS_CLK) disable iff (!RSTN)
      (REG_WR && REG_ADDR == ADDR_MASK_CLR && REG_WDATA[POS_IRQ_WR])
      |=> !mask_wr_reg;
   endproperty
   a_clr_mask: assert property (p_clr_mask)
      else $error("wait-rise mask not cleared");

   property p_no_wait;
      @(posedge SYS_CLK) disable iff (!RSTN)
      (state_reg == ST_STROBE && !ew)
      |=> (state_reg != ST_STROBE || $stable(wait_cnt_reg));
   endproperty
   a_no_wait: assert property (p_no_wait)
      else $error("wait counted while disabled");

   property p_timeout;
      @(posedge SYS_CLK) disable iff (!RSTN)
      timeout_evt |=> stat_at_reg;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("timeout not flagged");

   property p_wait_lim;
      @(posedge SYS_CLK) disable iff (!RSTN)
      {1'b0, wait_cnt_reg} < wait_lim;
   endproperty
   a_wait_lim: assert property (p_wait_lim)
      else $error("wait beyond limit");

   property p_hold_exit;
      @(posedge SYS_CLK) disable iff (!RSTN)
      (state_reg == ST_HOLD && cnt_reg != {6'h0, hold_w})
      |=> state_reg == ST_HOLD;
   endproperty
   a_hold_exit: assert property (p_hold_exit)
      else $error("hold ended early");

   property p_setup_exit;
      @(posedge SYS_CLK) disable iff (!RSTN)
      (state_reg == ST_SETUP && cnt_reg != {6'h0, setup_w})
      |=> state_reg == ST_SETUP;
   endproperty
   a_setup_exit: assert property (p_setup_exit)
      else $error("setup ended early");

endmodule : amw_async_ctrl

// file: rtl/amw_pkg.sv
package amw_pkg;

   // -----------------------------------------------------------------
   // Register map (word offsets on the plain register port)
   // -----------------------------------------------------------------
   localparam logic [3:0] ADDR_TIMING   = 4'h0;
   localparam logic [3:0] ADDR_WAITCFG  = 4'h1;
   localparam logic [3:0] ADDR_MASK_SET = 4'h2;
   localparam logic [3:0] ADDR_MASK_CLR = 4'h3;
   localparam logic [3:0] ADDR_STATUS   = 4'h4;
   localparam logic [3:0] ADDR_CTRL     = 4'h5;

   // -----------------------------------------------------------------
   // Field positions in async_space_timing_config
   // -----------------------------------------------------------------
   localparam int POS_SS      = 31;
   localparam int POS_EW      = 30;
   localparam int POS_WSETUP  = 26;
   localparam int POS_WSTROBE = 20;
   localparam int POS_WHOLD   = 17;
   localparam int POS_RSETUP  = 13;
   localparam int POS_RSTROBE = 7;
   localparam int POS_RHOLD   = 4;
   localparam int POS_TA      = 2;
   localparam int POS_BUS_WIDTH_SEL   = 0;

   // Wait config, mask, status and control bit positions
   localparam int POS_MAX_WAIT_COUNT    = 0;
   localparam int POS_WP      = 28;
   localparam int POS_IRQ_AT  = 0;
   localparam int POS_IRQ_WR  = 1;
   localparam int POS_NAND    = 0;

   // Reset values
   localparam logic [31:0] RST_TIMING  = 32'h3FFF_FFFD;
   localparam logic [31:0] RST_WAITCFG = 32'h1000_0080;

   // Timing: wait-limit granule in clock cycles
   localparam int WAIT_GRANULE = 16;

   // Bus width encodings
   localparam logic [1:0] WIDTH_8  = 2'h0;
   localparam logic [1:0] WIDTH_16 = 2'h1;
   localparam logic [1:0] WIDTH_32 = 2'h2;

   // Requester transfer request
   typedef struct packed {
      logic        write;
      logic [21:0] addr;
      logic [31:0] wdata;
      logic [3:0]  be;
   } amw_req_t;

   // External pin bundle
   typedef struct packed {
      logic        cs_n;
      logic        oe_n;
      logic        we_n;
      logic [3:0]  lane_n;
      logic [21:0] addr;
      logic [1:0]  bank;
      logic [31:0] dout;
      logic        doe;
   } amw_pins_t;

endpackage : amw_pkg

// file: sim/amw_mem_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Asynchronous memory partner
// ------------------------------------------------------------
module amw_mem_model
   import amw_pkg::*;
(
   // Clock
   input  wire logic        clk,
   // Block pins
   input  wire amw_pins_t   pins,
   output logic      [31:0] data_out,
   output logic             wait_out,
   // Bench controls
   input  wire logic [7:0]  base,
   input  wire logic        restart,
   input  wire logic        wait_pol,
   input  wire logic        wait_pulse,
   input  wire logic [15:0] wait_len,
   output logic      [31:0] last_wdata
);
   logic [7:0]  beat    = 8'h00;
   logic [15:0] cnt     = 16'h0000;
   logic [31:0] last_rd = 32'h0000_0000;
   logic        prev_oe = 1'b1;
   logic        strobe;
   logic [7:0]  cur;

   // Each beat answers base plus beat number on every lane
   assign strobe   = !pins.oe_n || !pins.we_n;
   assign cur      = base + beat;
   // Released bus shows junk, so stale data cannot pass as read data
   assign data_out = !pins.oe_n ? {4{cur}} : ~last_rd;
   // Wait held active for wait_len cycles of each strobe
   assign wait_out = ((strobe && cnt < wait_len) || wait_pulse) ?
                     wait_pol : !wait_pol;

   // Beat counter, strobe age and captured write data
   always @(posedge clk) begin
      cnt     <= strobe ? cnt + 16'h0001 : 16'h0000;
      prev_oe <= pins.oe_n;
      if (!pins.oe_n)
         last_rd <= data_out;
      if (restart)
         beat <= 8'h00;
      else if (!prev_oe && pins.oe_n)
         beat <= beat + 8'h01;
      if (!pins.we_n && pins.doe)
         last_wdata <= pins.dout;
   end
endmodule : amw_mem_model

// file: sim/test_amw_async_ctrl.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_amw_async_ctrl;
   import amw_pkg::*;
   logic SYS_CLK, RSTN, REG_WR, REG_RD, REQ_VALID, REQ_READY, RSP_VALID;
   logic [3:0]  REG_ADDR;
   logic [31:0] REG_WDATA, REG_RDATA, RSP_DATA, DATA_IN, lw, v, d;
   logic        SDRAM_REQ, SDRAM_GRANT, WAIT_IN, IRQ, restart, pol, pulse;
   logic [7:0]  b;
   logic [15:0] wlen;
   amw_req_t    REQ;
   amw_pins_t   PINS;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   int n_fail, n_checks, rd_len, wr_len, rd_cur, wr_cur, rd_beats, wr_beats;
   int gap, gap_rw, rsp_seen, k;

   amw_async_ctrl amw_async_ctrl_i (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
      .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REQ(REQ),
      .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .RSP_DATA(RSP_DATA),
      .RSP_VALID(RSP_VALID), .SDRAM_REQ(SDRAM_REQ),
      .SDRAM_GRANT(SDRAM_GRANT), .PINS(PINS), .DATA_IN(DATA_IN),
      .WAIT_IN(WAIT_IN), .IRQ(IRQ));
   amw_mem_model amw_mem_model_i (.clk(SYS_CLK), .pins(PINS),
      .data_out(DATA_IN), .wait_out(WAIT_IN), .base(b), .restart(restart),
      .wait_pol(pol), .wait_pulse(pulse), .wait_len(wlen), .last_wdata(lw));

   // ------------------------------------------------------------
   // Clock, strobe monitor and response scoreboard
   // ------------------------------------------------------------
   initial begin
      SYS_CLK = 1'b0;
      forever #4 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK) begin
      if (!PINS.oe_n) begin
         rd_cur++;
         gap = 0;
      end else begin
         if (rd_cur != 0) begin
            rd_len = rd_cur;
            rd_beats++;
         end
         rd_cur = 0;
         gap++;
      end
      if (!PINS.we_n) begin
         if (wr_cur == 0 && wr_beats == 0) gap_rw = gap; // First beat only
         wr_cur++;
      end else begin
         if (wr_cur != 0) begin
            wr_len = wr_cur;
            wr_beats++;
         end
         wr_cur = 0;
      end
      if (RSP_VALID === 1'b1 && exp_q.size() != 0) begin
         e = exp_q.pop_front();
         rsp_seen++;
         if (e[32]) `CHK("rsp_data", e[31:0], RSP_DATA)
      end
   end

   // ------------------------------------------------------------
   // Bus tasks and reference values
   // ------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [31:0] dat);
      @(posedge SYS_CLK);
      REG_ADDR <= a; REG_WDATA <= dat; REG_WR <= 1'b1;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] dat);
      @(posedge SYS_CLK);
      REG_ADDR <= a; REG_RD <= 1'b1;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      #1 dat = REG_RDATA;
   endtask : rd
   // Timing word: setup 1, strobe 2, hold 1, turn gap 1
   function automatic logic [31:0] mk(input logic ew, input int w);
      return (32'(ew) << POS_EW) | (32'h1 << POS_WSETUP) |
         (32'h2 << POS_WSTROBE) | (32'h1 << POS_WHOLD) |
         (32'h1 << POS_RSETUP) | (32'h2 << POS_RSTROBE) |
         (32'h1 << POS_RHOLD) | (32'h1 << POS_TA) | 32'(w);
   endfunction : mk
   // Narrow beats land low lane first
   function automatic logic [31:0] exp_rd(input int w, input logic [7:0] x);
      if (w == 0) return {x + 8'h3, x + 8'h2, x + 8'h1, x};
      if (w == 1) return {x + 8'h1, x + 8'h1, x, x};
      return {4{x}};
   endfunction : exp_rd
   task automatic xfer(input logic w, input logic [32:0] ex);
      int i;
      int s;
      rd_beats = 0; wr_beats = 0; s = rsp_seen; i = 0;
      @(posedge SYS_CLK);
      REQ <= '{w, 22'h00_0010, d, 4'hF}; REQ_VALID <= 1'b1; restart <= 1'b1;
      exp_q.push_back(ex);
      do begin
         @(posedge SYS_CLK);
         restart <= 1'b0;
         i++;
      end while (REQ_READY !== 1'b1 && i < 100);
      REQ_VALID <= 1'b0;
      // Step past the edge so the scoreboard has counted the response
      for (i = 0; i < 3000 && rsp_seen == s; i++) begin
         @(posedge SYS_CLK);
         #1;
      end
      if (rsp_seen == s) `CHK("rsp_seen", s + 1, rsp_seen)
      repeat (2) @(posedge SYS_CLK);
   endtask : xfer
   task automatic results;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results

   // ------------------------------------------------------------
   // Watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      #400000;
      n_fail++;
      results();
   end
   initial begin
      RSTN = 1'b0; REG_WR = 1'b0; REG_RD = 1'b0; REG_ADDR = 4'h0;
      REG_WDATA = 32'h0; REQ = '0; REQ_VALID = 1'b0; SDRAM_REQ = 1'b0;
      restart = 1'b0; pol = 1'b1; pulse = 1'b0; wlen = 16'h0; b = 8'h0;
      d = 32'h0;
      void'($urandom(1));
      repeat (4) @(posedge SYS_CLK);
      RSTN <= 1'b1;
      rd(4'hF, v); `CHK("unmapped", 32'h0, v)
      // Widths 8, 16, 32: strobe, beats, turnaround; write data at 32 only
      for (int w = 0; w < 3; w++) begin
         wr(ADDR_TIMING, mk(1'b0, w));
         b = 8'($urandom); d = $urandom;
         xfer(1'b0, {1'b1, exp_rd(w, b)});
         `CHK("rd_strobe", 3, rd_len)
         `CHK("rd_beats", 4 >> w, rd_beats)
         xfer(1'b1, 33'h0);
         `CHK("wr_strobe", 3, wr_len)
         `CHK("wr_beats", 4 >> w, wr_beats)
         // Hold 2, bench idle 5, turn 2, setup 2: strobes 12 apart
         `CHK("turn_gap", 12, gap_rw)
         if (w == 2) `CHK("wdata", d, lw)
      end
      // Wait polarity and long-wait gating; strobe fields nonzero
      wlen = 16'd8;
      for (int p = 0; p < 2; p++) begin
         pol = p[0];
         wr(ADDR_WAITCFG, (32'(p) << POS_WP) | 32'h0F);
         wr(ADDR_TIMING, mk(1'b1, 2));
         xfer(1'b0, {1'b1, {4{b}}});
         `CHK("wait_len", 1'b1, rd_len >= 8 && rd_len <= 14)
         wr(ADDR_TIMING, mk(1'b0, 2));
         xfer(1'b0, {1'b1, {4{b}}});
         `CHK("no_wait", 3, rd_len)
      end
      // Timeout after 16 cycles, masked then unmasked
      wlen = 16'd1000;
      wr(ADDR_WAITCFG, 32'h1000_0000);
      wr(ADDR_TIMING, mk(1'b1, 2));
      xfer(1'b0, {1'b1, {4{b}}});
      `CHK("tmo_len", 1'b1, rd_len >= 16 && rd_len <= 22)
      rd(ADDR_STATUS, v); `CHK("tmo_flag", 1'b1, v[POS_IRQ_AT])
      `CHK("irq_masked", 1'b0, IRQ)
      // IRQ is registered: it follows the mask one edge later
      wr(ADDR_MASK_SET, 32'h1); @(posedge SYS_CLK); #1;
      `CHK("irq_on", 1'b1, IRQ)
      wr(ADDR_MASK_CLR, 32'h1); @(posedge SYS_CLK); #1;
      `CHK("irq_off", 1'b0, IRQ)
      wr(ADDR_MASK_SET, 32'h3); wr(ADDR_MASK_CLR, 32'h2);
      wr(ADDR_MASK_SET, 32'h0);
      rd(ADDR_MASK_SET, v); `CHK("mask_set", 32'h1, v)
      rd(ADDR_MASK_CLR, v); `CHK("mask_clr", 32'h1, v)
      wr(ADDR_MASK_CLR, 32'h1); wr(ADDR_STATUS, 32'h3);
      // Wait rise in NAND mode; long wait off first
      wlen = 16'd0; pol = 1'b1;
      wr(ADDR_TIMING, mk(1'b0, 2));
      wr(ADDR_CTRL, 32'h1); wr(ADDR_MASK_SET, 32'h2);
      pulse <= 1'b1; repeat (3) @(posedge SYS_CLK); pulse <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
      `CHK("wrise_irq", 1'b1, IRQ)
      wr(ADDR_MASK_CLR, 32'h2); @(posedge SYS_CLK); #1;
      `CHK("wrise_off", 1'b0, IRQ)
      wr(ADDR_CTRL, 32'h0);
      // Hand-off to SDRAM after the turn gap
      SDRAM_REQ <= 1'b1; k = 0;
      do begin
         @(posedge SYS_CLK);
         k++;
      end while (SDRAM_GRANT !== 1'b1 && k < 60);
      `CHK("sdram_gap", 1'b1, k >= 2 && k < 60)
      SDRAM_REQ <= 1'b0;
      repeat (4) @(posedge SYS_CLK);
      results();
   end
endmodule : test_amw_async_ctrl
